/* File: seq_pkg.sv */
package seq_pkg;

  // ----------------------------------------
  // Comparator input indices
  // ----------------------------------------
  localparam int IN_ABOVE_ON    = 0;
  localparam int IN_BELOW_OFF   = 1;
  localparam int IN_BELOW_STUP  = 2;
  localparam int IN_BELOW_RESET = 3;
  localparam int IN_TEMP_UPPER  = 4;
  localparam int IN_TEMP_LOWER  = 5;
  localparam int IN_BO_UPPER    = 6;
  localparam int IN_BO_LOWER    = 7;
  localparam int IN_UNDERVOLT   = 8;
  localparam int IN_EXT_REQ     = 9;
  localparam int NUM_INPUTS     = 10;

  // ----------------------------------------
  // Supply phases
  // ----------------------------------------
  localparam int PHASE_W = 2;
  typedef enum logic [PHASE_W-1:0] {
    PH_RESET       = 2'b00,
    PH_STARTUP     = 2'b01,
    PH_WORKING     = 2'b10,
    PH_LATCHED_OFF = 2'b11
  } phase_t;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_EVENTS = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_MASK   = 4'hc;

  // Control fields and reset value
  localparam int CTRL_DRIVE_ALLOW = 0;
  localparam logic CTRL_DRIVE_ALLOW_RST = 1'b1;

  // Status fields
  localparam int ST_PHASE_LSB = 0;
  localparam int ST_OFF       = 2;
  localparam int ST_SOURCE    = 3;
  localparam int ST_OVERTEMP  = 4;
  localparam int ST_BROWNOUT  = 5;
  localparam int ST_EXT_LATCH = 6;
  localparam int ST_UNDERVOLT = 7;

  // Event fields (events and mask share this layout)
  localparam int EV_WORKING    = 0;
  localparam int EV_LATCHED    = 1;
  localparam int EV_STARTUP    = 2;
  localparam int EV_FULL_RESET = 3;
  localparam int EV_FAULT      = 4;
  localparam int EV_W          = 5;
  localparam logic [EV_W-1:0] MASK_RST   = 5'h00;
  localparam logic [EV_W-1:0] EVENTS_RST = 5'h00;

endpackage

/* File: sync_if.sv */
`timescale 1ns/1ps
interface sync_if;
  logic [seq_pkg::NUM_INPUTS-1:0] raw;
  logic [seq_pkg::NUM_INPUTS-1:0] synced;
  modport sync_side (input raw, output synced);
  modport user_side (output raw, input synced);
endinterface // sync_if

/* File: input_synchronizer.sv */
`timescale 1ns/1ps
module input_synchronizer (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  sync_if.sync_side sig
);
  import seq_pkg::*;

  logic [NUM_INPUTS-1:0] stage1;
  logic [NUM_INPUTS-1:0] stage2;

  // Two-flop synchroniser, first stage read only by second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= sig.raw;
      stage2 <= stage1;
    end
  end

  assign sig.synced = stage2;

endmodule // input_synchronizer

/* File: supply_level_off_state_sequencer.sv */
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// How it works
// - Gate drive output held low throughout OFF state.
// - OFF state powers down all blocks except monitors, protections and latch.
// - Brown-out comparator reset in latched-off phase, upper threshold next time.
// - In OFF, startup source enabled once supply drops below startup level, and stays on until turn-on level.
// - Soft-start capacitor discharged and grounded throughout OFF state.
// - OFF drives stage ready flag low and grounds on-time processing output.
// - External shutdown latch keeps its value on entering OFF.
// - Above turn-on level: source off, active unless an off condition exists.
// - Below turn-off level: enter latched-off phase regardless of protections.
// - Below startup level: startup source turns on to recharge supply.
// - Startup phase holds gate drive and stage ready flag low.
// - Startup resets all blocks but overtemp, brown-out and shutdown latch.
// - Below reset level: source on, everything reset including latch, overtemp.
// - After full reset: upper overtemp threshold, shutdown latch output low.
// - While startup source on, brown-out active with upper threshold.
// - Off condition during charge, lockout, overtemp, brown-out, undervoltage, shutdown.
// - Lockout holds off until next charge completes; shutdown latch holds until full reset; other faults release at once.
module supply_level_off_state_sequencer (
  input  wire logic                         clk_i,
  input  wire logic                         reset_n_i,
  input  wire logic                         supply_above_on_i,
  input  wire logic                         supply_below_off_i,
  input  wire logic                         supply_below_startup_i,
  input  wire logic                         supply_below_reset_i,
  input  wire logic                         temp_above_upper_i,
  input  wire logic                         temp_above_lower_i,
  input  wire logic                         brownout_above_upper_i,
  input  wire logic                         brownout_above_lower_i,
  input  wire logic                         output_undervoltage_i,
  input  wire logic                         ext_shutdown_request_i,
  input  wire logic                         pwm_request_i,
  input  wire logic [seq_pkg::ADDR_W-1:0]   avs_address_i,
  input  wire logic                         avs_read_i,
  input  wire logic                         avs_write_i,
  input  wire logic [seq_pkg::DATA_W-1:0]   avs_writedata_i,
  input  wire logic [3:0]                   avs_byteenable_i,
  output logic      [seq_pkg::DATA_W-1:0]   avs_readdata_o,
  output logic                              avs_waitrequest_o,
  output logic                              irq_o,
  output logic                              gate_drive_o,
  output logic                              stage_ready_flag_o,
  output logic                              startup_source_en_o,
  output logic                              softstart_discharge_o,
  output logic                              on_time_clamp_o,
  output logic                              block_power_down_o,
  output logic                              block_reset_o,
  output logic                              brownout_reset_o,
  output logic                              overtemp_upper_sel_o,
  output logic                              external_shutdown_latch_o,
  output logic                              off_condition_o,
  output logic      [seq_pkg::PHASE_W-1:0]  phase_o
);
  import seq_pkg::*;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta_n;
  logic rst_n;

  // Asynchronous assert, two-flop release
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  sync_if cmp ();

  // Gather raw comparator pins
  always_comb begin
    cmp.raw                 = '0;
    cmp.raw[IN_ABOVE_ON]    = supply_above_on_i;
    cmp.raw[IN_BELOW_OFF]   = supply_below_off_i;
    cmp.raw[IN_BELOW_STUP]  = supply_below_startup_i;
    cmp.raw[IN_BELOW_RESET] = supply_below_reset_i;
    cmp.raw[IN_TEMP_UPPER]  = temp_above_upper_i;
    cmp.raw[IN_TEMP_LOWER]  = temp_above_lower_i;
    cmp.raw[IN_BO_UPPER]    = brownout_above_upper_i;
    cmp.raw[IN_BO_LOWER]    = brownout_above_lower_i;
    cmp.raw[IN_UNDERVOLT]   = output_undervoltage_i;
    cmp.raw[IN_EXT_REQ]     = ext_shutdown_request_i;
  end

  input_synchronizer u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .sig     (cmp.sync_side)
  );

  // Synchronised flags only
  wire above_on    = cmp.synced[IN_ABOVE_ON];
  wire below_off   = cmp.synced[IN_BELOW_OFF];
  wire below_stup  = cmp.synced[IN_BELOW_STUP];
  wire below_reset = cmp.synced[IN_BELOW_RESET];
  wire temp_upper  = cmp.synced[IN_TEMP_UPPER];
  wire temp_lower  = cmp.synced[IN_TEMP_LOWER];
  wire bo_upper    = cmp.synced[IN_BO_UPPER];
  wire bo_lower    = cmp.synced[IN_BO_LOWER];
  wire undervolt   = cmp.synced[IN_UNDERVOLT];
  wire ext_req     = cmp.synced[IN_EXT_REQ];

  // ----------------------------------------
  // Supply phase sequencing
  // ----------------------------------------
  phase_t phase;
  phase_t next_phase;

  // Next phase from supply thresholds
  always_comb begin
    next_phase = phase;
    if (below_reset) begin
      next_phase = PH_RESET;
    end else if (below_stup) begin
      next_phase = PH_STARTUP;
    end else begin
      unique case (phase)
        PH_RESET:       next_phase = PH_STARTUP;
        PH_STARTUP: begin
          if (above_on) begin
            next_phase = PH_WORKING;
          end
        end
        PH_WORKING: begin
          if (below_off) begin
            next_phase = PH_LATCHED_OFF;
          end
        end
        PH_LATCHED_OFF: next_phase = PH_LATCHED_OFF;
      endcase
    end
  end

  // Phase register
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      phase <= PH_RESET;
    end else begin
      phase <= next_phase;
    end
  end

  // Source runs in startup and reset phases only
  wire source_on  = (phase == PH_STARTUP) || (phase == PH_RESET);
  wire full_reset = (phase == PH_RESET);

  // ----------------------------------------
  // Overtemperature shutdown
  // ----------------------------------------
  logic overtemp_shutdown;

  // Hysteresis between upper and lower thresholds
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      overtemp_shutdown <= 1'b0;
    end else if (full_reset) begin
      overtemp_shutdown <= 1'b0;
    end else if (!overtemp_shutdown && temp_upper) begin
      overtemp_shutdown <= 1'b1;
    end else if (overtemp_shutdown && !temp_lower) begin
      overtemp_shutdown <= 1'b0;
    end
  end

  // ----------------------------------------
  // Brown-out detection
  // ----------------------------------------
  logic brownout_fault;
  logic bo_force_upper;

  // Comparator held at upper threshold
  assign bo_force_upper = (phase == PH_LATCHED_OFF) || source_on;

  // Hysteresis, or upper threshold while forced
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      brownout_fault <= 1'b1;
    end else if (bo_force_upper) begin
      brownout_fault <= !bo_upper;
    end else if (brownout_fault && bo_upper) begin
      brownout_fault <= 1'b0;
    end else if (!brownout_fault && !bo_lower) begin
      brownout_fault <= 1'b1;
    end
  end

  // ----------------------------------------
  // External shutdown latch
  // ----------------------------------------
  logic external_shutdown_latch;

  // Set by request, cleared only by full reset
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      external_shutdown_latch <= 1'b0;
    end else if (full_reset) begin
      external_shutdown_latch <= 1'b0;
    end else if (ext_req) begin
      external_shutdown_latch <= 1'b1;
    end
  end

  // ----------------------------------------
  // Off condition
  // ----------------------------------------
  // Faults: all but the shutdown latch release as soon as they clear
  wire fault_any = overtemp_shutdown | brownout_fault | undervolt | external_shutdown_latch;

  // Lockout held by phase until next charge ends
  wire off_now   = source_on | (phase != PH_WORKING) | fault_any;

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  logic drive_allow;
  logic bus_ack;
  wire  bus_req = avs_read_i | avs_write_i;
  wire  wr_fire = avs_write_i & bus_ack;
  wire  rd_fire = avs_read_i & bus_ack;

  // Software gate enable
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      drive_allow <= CTRL_DRIVE_ALLOW_RST;
    end else if (wr_fire && avs_address_i == OFS_CTRL && avs_byteenable_i[0]) begin
      drive_allow <= avs_writedata_i[CTRL_DRIVE_ALLOW];
    end
  end

  // ----------------------------------------
  // Block outputs
  // ----------------------------------------
  // Registered output gating
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      gate_drive_o          <= 1'b0;
      stage_ready_flag_o    <= 1'b0;
      softstart_discharge_o <= 1'b1;
      on_time_clamp_o       <= 1'b1;
      block_power_down_o    <= 1'b1;
      block_reset_o         <= 1'b1;
      startup_source_en_o   <= 1'b1;
      brownout_reset_o      <= 1'b1;
      off_condition_o       <= 1'b1;
    end else begin
      gate_drive_o          <= pwm_request_i & drive_allow & !off_now;
      stage_ready_flag_o    <= !off_now;
      softstart_discharge_o <= off_now;
      on_time_clamp_o       <= off_now;
      block_power_down_o    <= off_now;
      block_reset_o         <= source_on;
      startup_source_en_o   <= source_on;
      brownout_reset_o      <= bo_force_upper;
      off_condition_o       <= off_now;
    end
  end

  assign overtemp_upper_sel_o      = !overtemp_shutdown;
  assign external_shutdown_latch_o = external_shutdown_latch;
  assign phase_o                   = phase;

  // ----------------------------------------
  // Event capture and interrupt
  // ----------------------------------------
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] mask;
  logic [EV_W-1:0] ev_pulse;
  logic            phase_change;

  assign phase_change = (next_phase != phase);

  // Event pulses from phase entry and new faults
  always_comb begin
    ev_pulse                = '0;
    ev_pulse[EV_WORKING]    = phase_change && next_phase == PH_WORKING;
    ev_pulse[EV_LATCHED]    = phase_change && next_phase == PH_LATCHED_OFF;
    ev_pulse[EV_STARTUP]    = phase_change && next_phase == PH_STARTUP;
    ev_pulse[EV_FULL_RESET] = phase_change && next_phase == PH_RESET;
    ev_pulse[EV_FAULT]      = (phase == PH_WORKING) && fault_any && !off_condition_o;
  end

  // Sticky bits, read clears, new event wins
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      events <= EVENTS_RST;
    end else if (rd_fire && avs_address_i == OFS_EVENTS) begin
      events <= ev_pulse;
    end else begin
      events <= events | ev_pulse;
    end
  end

  // Interrupt mask
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mask <= MASK_RST;
    end else if (wr_fire && avs_address_i == OFS_MASK && avs_byteenable_i[0]) begin
      mask <= avs_writedata_i[EV_W-1:0];
    end
  end

  // Level interrupt
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(events & mask);
    end
  end

  // ----------------------------------------
  // Avalon-MM slave
  // ----------------------------------------
  logic [DATA_W-1:0] status_word;

  // Status word assembly
  always_comb begin
    status_word = '0;
    status_word[ST_PHASE_LSB +: PHASE_W] = phase;
    status_word[ST_OFF]       = off_now;
    status_word[ST_SOURCE]    = source_on;
    status_word[ST_OVERTEMP]  = overtemp_shutdown;
    status_word[ST_BROWNOUT]  = brownout_fault;
    status_word[ST_EXT_LATCH] = external_shutdown_latch;
    status_word[ST_UNDERVOLT] = undervolt;
  end

  // One wait cycle per access
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= bus_req & !bus_ack;
    end
  end

  assign avs_waitrequest_o = bus_req & !bus_ack;

  // Read data captured while waiting
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata_o <= '0;
    end else if (avs_read_i && !bus_ack) begin
      unique case (avs_address_i)
        OFS_CTRL:   avs_readdata_o <= {{(DATA_W-1){1'b0}}, drive_allow};
        OFS_STATUS: avs_readdata_o <= status_word;
        OFS_EVENTS: avs_readdata_o <= {{(DATA_W-EV_W){1'b0}}, events | ev_pulse};
        OFS_MASK:   avs_readdata_o <= {{(DATA_W-EV_W){1'b0}}, mask};
        default:    avs_readdata_o <= '0;
      endcase
    end
  end

endmodule // supply_level_off_state_sequencer

/* File: supply_level_off_state_sequencer_assertions.sv */
`timescale 1ns/1ps
module supply_level_off_state_sequencer_assertions
  import seq_pkg::*;
(
  input wire logic               clk_i,
  input wire logic               reset_n_i,
  input wire logic               supply_above_on_i,
  input wire logic               supply_below_off_i,
  input wire logic               supply_below_startup_i,
  input wire logic               supply_below_reset_i,
  input wire logic               gate_drive_o,
  input wire logic               stage_ready_flag_o,
  input wire logic               startup_source_en_o,
  input wire logic               softstart_discharge_o,
  input wire logic               on_time_clamp_o,
  input wire logic               block_power_down_o,
  input wire logic               block_reset_o,
  input wire logic               brownout_reset_o,
  input wire logic               overtemp_upper_sel_o,
  input wire logic               external_shutdown_latch_o,
  input wire logic               off_condition_o,
  input wire logic [PHASE_W-1:0] phase_o
);
  // Single clock domain, raw reset pin disables all checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // ----------------------------------------
  // Output gating while off
  // ----------------------------------------
  property p_gate_off; off_condition_o |-> !gate_drive_o; endproperty
  a_gate_off: assert property (p_gate_off) else $error("gate drive high while off");
  property p_power_down; block_power_down_o == off_condition_o; endproperty
  a_power_down: assert property (p_power_down) else $error("power down differs from off");
  property p_softstart; softstart_discharge_o == off_condition_o; endproperty
  a_softstart: assert property (p_softstart) else $error("soft-start discharge differs from off");
  property p_ready_clamp; stage_ready_flag_o == !off_condition_o && on_time_clamp_o == off_condition_o; endproperty
  a_ready_clamp: assert property (p_ready_clamp) else $error("ready flag or clamp wrong");
  property p_source_blocks; startup_source_en_o |-> off_condition_o && block_reset_o && brownout_reset_o; endproperty
  a_source_blocks: assert property (p_source_blocks) else $error("source on without off and resets");

  // ----------------------------------------
  // Phase sequencing
  // ----------------------------------------
  sequence s_charged;
    phase_o == PH_STARTUP && supply_above_on_i && !supply_below_off_i && !supply_below_startup_i;
  endsequence
  sequence s_lockout;
    phase_o == PH_WORKING && supply_below_off_i && !supply_below_startup_i;
  endsequence
  sequence s_latched_quiet;
    (!supply_below_startup_i && !supply_below_reset_i) [*3] ##0 phase_o == PH_LATCHED_OFF;
  endsequence
  property p_source_phase; startup_source_en_o == !$past(phase_o[1]); endproperty
  a_source_phase: assert property (p_source_phase) else $error("source enable not from phase");
  property p_turn_on; s_charged |-> ##[1:4] phase_o == PH_WORKING; endproperty
  a_turn_on: assert property (p_turn_on) else $error("working phase not entered");
  property p_lockout; s_lockout |-> ##[1:4] phase_o == PH_LATCHED_OFF; endproperty
  a_lockout: assert property (p_lockout) else $error("latched-off phase not entered");
  property p_latched_hold; s_latched_quiet |=> phase_o == PH_LATCHED_OFF; endproperty
  a_latched_hold: assert property (p_latched_hold) else $error("latched-off left early");
  property p_bo_reset; phase_o == PH_LATCHED_OFF |=> brownout_reset_o; endproperty
  a_bo_reset: assert property (p_bo_reset) else $error("brown-out not reset when latched");
  property p_latch_hold;
    external_shutdown_latch_o && phase_o != PH_RESET |=> external_shutdown_latch_o || phase_o == PH_RESET;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("shutdown latch lost its value");
  property p_full_reset;
    (phase_o == PH_RESET) [*2] |-> !external_shutdown_latch_o && overtemp_upper_sel_o;
  endproperty
  a_full_reset: assert property (p_full_reset) else $error("full reset left latch or threshold");
endmodule // supply_level_off_state_sequencer_assertions

bind supply_level_off_state_sequencer supply_level_off_state_sequencer_assertions chk (
  .clk_i, .reset_n_i, .supply_above_on_i, .supply_below_off_i, .supply_below_startup_i,
  .supply_below_reset_i, .gate_drive_o, .stage_ready_flag_o, .startup_source_en_o,
  .softstart_discharge_o, .on_time_clamp_o, .block_power_down_o, .block_reset_o,
  .brownout_reset_o, .overtemp_upper_sel_o, .external_shutdown_latch_o, .off_condition_o, .phase_o
);

/* File: supply_level_off_state_sequencer_tb.sv */
`timescale 1ns/1ps
module supply_level_off_state_sequencer_tb;
  import seq_pkg::*;

  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic              clk_i = 1'b0;
  logic              reset_n_i = 1'b0;
  logic              supply_above_on_i = 1'b0;
  logic              supply_below_off_i = 1'b1;
  logic              supply_below_startup_i = 1'b1;
  logic              supply_below_reset_i = 1'b1;
  logic              temp_above_upper_i = 1'b0;
  logic              temp_above_lower_i = 1'b0;
  logic              brownout_above_upper_i = 1'b1;
  logic              brownout_above_lower_i = 1'b1;
  logic              output_undervoltage_i = 1'b0;
  logic              ext_shutdown_request_i = 1'b0;
  logic              pwm_request_i = 1'b1;
  logic [ADDR_W-1:0] avs_address_i = 4'h0;
  logic              avs_read_i = 1'b0;
  logic              avs_write_i = 1'b0;
  logic [DATA_W-1:0] avs_writedata_i = 32'h0;
  logic [3:0]        avs_byteenable_i = 4'h1;
  logic [DATA_W-1:0] avs_readdata_o;
  logic              avs_waitrequest_o, irq_o, gate_drive_o, stage_ready_flag_o, startup_source_en_o;
  logic              softstart_discharge_o, on_time_clamp_o, block_power_down_o, block_reset_o;
  logic              brownout_reset_o, overtemp_upper_sel_o, external_shutdown_latch_o, off_condition_o;
  logic [PHASE_W-1:0] phase_o;
  logic [5:0]        fault_set [3] = '{6'h3c, 6'h00, 6'h0e};
  localparam logic [31:0] ALL = 32'hffff_ffff;
  int                failures = 0;
  int                compares = 0;
  int                cycles = 0;

  supply_level_off_state_sequencer DUT (
    .clk_i, .reset_n_i, .supply_above_on_i, .supply_below_off_i, .supply_below_startup_i,
    .supply_below_reset_i, .temp_above_upper_i, .temp_above_lower_i, .brownout_above_upper_i,
    .brownout_above_lower_i, .output_undervoltage_i, .ext_shutdown_request_i, .pwm_request_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o, .irq_o, .gate_drive_o, .stage_ready_flag_o, .startup_source_en_o,
    .softstart_discharge_o, .on_time_clamp_o, .block_power_down_o, .block_reset_o, .brownout_reset_o,
    .overtemp_upper_sel_o, .external_shutdown_latch_o, .off_condition_o, .phase_o
  );

  // Clock and hang guard
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      failures = failures + 1;
      complete_run();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic settle();
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic supply(input logic [3:0] v);
    @(posedge clk_i);
    {supply_above_on_i, supply_below_off_i, supply_below_startup_i, supply_below_reset_i} <= v;
    settle();
  endtask
  task automatic faults(input logic [5:0] v);
    @(posedge clk_i);
    {temp_above_upper_i, temp_above_lower_i, brownout_above_upper_i, brownout_above_lower_i,
     output_undervoltage_i, ext_shutdown_request_i} <= v;
    settle();
  endtask
  task automatic outs(input logic g, input logic s, input logic o, input phase_t ph);
    check("outputs", {gate_drive_o, stage_ready_flag_o, startup_source_en_o, off_condition_o, block_reset_o,
          softstart_discharge_o, on_time_clamp_o, block_power_down_o, phase_o}, {g, !o, s, o, s, o, o, o, ph});
  endtask
  // Bus handshake: hold until waitrequest is seen low at a rising edge
  task automatic handshake();
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [3:0] be);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    avs_write_i <= 1'b1;
    handshake();
    avs_write_i <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [DATA_W-1:0] d;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    handshake();
    d = avs_readdata_o;
    avs_read_i <= 1'b0;
    check("readdata", d & m, exp);
  endtask
  task automatic irq_is(input logic exp);
    repeat (3) @(negedge clk_i);
    check("irq", irq_o, exp);
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    settle();
    outs(1'b0, 1'b1, 1'b1, PH_RESET);
    check("latch_sel", {external_shutdown_latch_o, overtemp_upper_sel_o}, 2'b01);
    rd(OFS_CTRL, 32'h1, ALL);
    rd(OFS_MASK, 32'h0, ALL);
    rd(4'h6, 32'h0, ALL);
    $display("test reset done");
    supply(4'h6);
    outs(1'b0, 1'b1, 1'b1, PH_STARTUP);
    check("block_resets", {block_reset_o, brownout_reset_o}, 2'b11);
    faults(6'h04);
    rd(OFS_STATUS, 32'h2d, ALL);
    faults(6'h0c);
    rd(OFS_EVENTS, 32'h4, 32'h4);
    wr(OFS_MASK, 32'h1, 4'h1);
    irq_is(1'b0);
    $display("test startup done");
    supply(4'h8);
    outs(1'b1, 1'b0, 1'b0, PH_WORKING);
    irq_is(1'b1);
    rd(OFS_STATUS, 32'h02, ALL);
    wr(OFS_STATUS, ALL, 4'hf);
    rd(OFS_STATUS, 32'h02, ALL);
    rd(OFS_EVENTS, 32'h1, ALL);
    irq_is(1'b0);
    wr(OFS_CTRL, 32'h0, 4'h0);
    settle();
    outs(1'b1, 1'b0, 1'b0, PH_WORKING);
    wr(OFS_CTRL, 32'h0, 4'h1);
    settle();
    check("gate", gate_drive_o, 1'b0);
    wr(OFS_CTRL, 32'h1, 4'h1);
    pwm_request_i <= 1'b0;
    settle();
    check("gate_pwm", gate_drive_o, 1'b0);
    @(posedge clk_i);
    pwm_request_i <= 1'b1;
    $display("test working done");
    for (int i = 0; i < 3; i++) begin
      faults(fault_set[i]);
      outs(1'b0, 1'b0, 1'b1, PH_WORKING);
      faults(6'h0c);
      outs(1'b1, 1'b0, 1'b0, PH_WORKING);
    end
    faults(6'h3c);
    wr(OFS_MASK, 32'h10, 4'h1);
    irq_is(1'b1);
    faults(6'h1c);
    outs(1'b0, 1'b0, 1'b1, PH_WORKING);
    check("overtemp_sel", overtemp_upper_sel_o, 1'b0);
    faults(6'h0c);
    outs(1'b1, 1'b0, 1'b0, PH_WORKING);
    rd(OFS_EVENTS, 32'h10, 32'h10);
    irq_is(1'b0);
    wr(OFS_MASK, 32'h0, 4'h1);
    $display("test faults done");
    faults(6'h0d);
    faults(6'h0c);
    outs(1'b0, 1'b0, 1'b1, PH_WORKING);
    supply(4'h4);
    outs(1'b0, 1'b0, 1'b1, PH_LATCHED_OFF);
    check("bo_latch", {brownout_reset_o, external_shutdown_latch_o}, 2'b11);
    rd(OFS_STATUS, 32'h47, ALL);
    supply(4'h8);
    outs(1'b0, 1'b0, 1'b1, PH_LATCHED_OFF);
    supply(4'h6);
    outs(1'b0, 1'b1, 1'b1, PH_STARTUP);
    check("latch", external_shutdown_latch_o, 1'b1);
    supply(4'h7);
    outs(1'b0, 1'b1, 1'b1, PH_RESET);
    check("latch_sel", {external_shutdown_latch_o, overtemp_upper_sel_o}, 2'b01);
    $display("test lockout done");
    supply(4'h6);
    supply(4'h8);
    outs(1'b1, 1'b0, 1'b0, PH_WORKING);
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    settle();
    outs(1'b0, 1'b1, 1'b1, PH_RESET);
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    settle();
    settle();
    outs(1'b1, 1'b0, 1'b0, PH_WORKING);
    $display("test recovery done");
    complete_run();
  end
endmodule // supply_level_off_state_sequencer_tb
